// >>> design/aacr_chan_if.sv
// Purpose: Carries one channel's level-change request and applied level.
// Assumes: Single clock domain, mclk.
// Notes:   The top drives the request side; the channel drives the level.
`timescale 1ns/100ps
interface aacr_chan_if;
	logic                            frame_tick; // One pulse per sample period.
	logic                            zero_cross; // Signal crossed zero this sample.
	aacr_pkg::aacr_mode_t            mode;       // Level-change mode.
	logic signed [aacr_pkg::LVL_W-1:0] target;   // Requested level.
	logic signed [aacr_pkg::LVL_W-1:0] level;    // Applied level.
	modport ctl (output frame_tick, output zero_cross, output mode, output target, input level);
	modport chan (input frame_tick, input zero_cross, input mode, input target, output level);
endinterface

// >>> design/aacr_level_chan.sv
// Purpose: Moves one channel's applied level toward its target.
// Assumes: frame_tick pulses once per sample period.
// Notes:   One instance per channel, so zero crossings are tracked apart.
`timescale 1ns/100ps
module aacr_level_chan #(
	parameter int TIMEOUT = aacr_pkg::TIMEOUT_SAMP
) (
	input  wire logic mclk,
	input  wire logic reset_n,
	aacr_chan_if.chan ch
);
	// ==========================================================
	// State.
	logic signed [aacr_pkg::LVL_W-1:0] level_ff;   // Applied level.
	logic [9:0]                        to_cnt_ff;  // Samples waited for a crossing.
	logic                              moving;     // Target differs from level.
	logic                              event_ok;   // Crossing seen or timeout hit.
	logic signed [aacr_pkg::LVL_W-1:0] step_level; // Level one 1/8 dB nearer target.

	assign ch.level   = level_ff;
	assign moving     = (level_ff != ch.target);
	assign event_ok   = ch.zero_cross || (ch.frame_tick && to_cnt_ff == 10'(TIMEOUT - 1));
	assign step_level = (level_ff < ch.target) ? level_ff + 8'sd1 : level_ff - 8'sd1;

	// ==========================================================
	// Timeout counter counts samples while a change waits on a crossing.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			to_cnt_ff <= 10'h000;
		end else if (!moving || event_ok) begin
			to_cnt_ff <= 10'h000;
		end else if (ch.frame_tick) begin
			to_cnt_ff <= to_cnt_ff + 10'h001;
		end
	end

	// ==========================================================
	// Level update by mode.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			level_ff <= '0;
		end else if (moving) begin
			unique case (ch.mode)
				aacr_pkg::AACR_IMMEDIATE: begin
					level_ff <= ch.target;
				end
				aacr_pkg::AACR_SOFT_ONLY: begin
					// One 1/8 dB step per frame gives 1 dB per 8 frames.
					if (ch.frame_tick) begin
						level_ff <= step_level;
					end
				end
				aacr_pkg::AACR_ZERO_ONLY: begin
					if (event_ok) begin
						level_ff <= ch.target;
					end
				end
				aacr_pkg::AACR_SOFT_ZERO: begin
					if (event_ok) begin
						level_ff <= step_level;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Checks.
	imm_apply_a: assert property (@(posedge mclk) disable iff (!reset_n)
		(ch.mode == aacr_pkg::AACR_IMMEDIATE && moving && $stable(ch.mode) ) |=> (level_ff == $past(ch.target)))
		else $error("Immediate mode did not apply target.");
	soft_step_a: assert property (@(posedge mclk) disable iff (!reset_n)
		(ch.mode == aacr_pkg::AACR_SOFT_ONLY && !ch.frame_tick) |=> $stable(level_ff))
		else $error("Soft ramp moved without a frame tick.");
	zero_wait_a: assert property (@(posedge mclk) disable iff (!reset_n)
		(ch.mode == aacr_pkg::AACR_ZERO_ONLY && !event_ok) |=> $stable(level_ff))
		else $error("Zero-cross change applied without crossing or timeout.");
endmodule

// >>> design/aacr_pkg.sv
// Purpose: Shared constants for the audio converter control register bank.
// Assumes: Byte-wide registers at byte addresses; level units are 1/8 dB.
// Notes:   Offsets, most field positions, reset values and the zero-cross timeout live here.
package aacr_pkg;
	// ==========================================================
	// Register offsets.
	localparam logic [7:0] ADDR_IDENT  = 8'h01; // Identification, read-only.
	localparam logic [7:0] ADDR_POWER  = 8'h02; // Power control.
	localparam logic [7:0] ADDR_CONV   = 8'h04; // Converter control.
	localparam logic [7:0] ADDR_CLKDIV = 8'h05; // Master clock divider.
	localparam logic [7:0] ADDR_GOUT   = 8'h06; // Gain-stage output control.
	localparam logic [7:0] ADDR_GAIN_B = 8'h07; // Channel B gain.
	localparam logic [7:0] ADDR_GAIN_A = 8'h08; // Channel A gain.
	localparam logic [7:0] ADDR_INPUT  = 8'h09; // Input and ramp control.

	// ==========================================================
	// Reset values; reserved bits hold their defaults.
	localparam logic [7:0] RST_POWER  = 8'h01;
	localparam logic [7:0] RST_CONV   = 8'h00;
	localparam logic [7:0] RST_CLKDIV = 8'h00;
	localparam logic [7:0] RST_GOUT   = 8'h40;
	localparam logic [7:0] RST_GAIN   = 8'h00;
	localparam logic [7:0] RST_INPUT  = 8'h19;

	// ==========================================================
	// Writable-bit masks; bits outside a mask keep their reset value.
	localparam logic [7:0] WM_POWER  = 8'h8d;
	localparam logic [7:0] WM_CONV   = 8'hd7;
	localparam logic [7:0] WM_CLKDIV = 8'h70;
	localparam logic [7:0] WM_GOUT   = 8'h40;
	localparam logic [7:0] WM_GAIN   = 8'h3f;
	localparam logic [7:0] WM_INPUT  = 8'h1f;

	// ==========================================================
	// Field positions.
	localparam int POS_FREEZE  = 7;
	localparam int POS_PD_MIC  = 3;
	localparam int POS_PD_CONV = 2;
	localparam int POS_PD_ALL  = 0;
	localparam int POS_SPEED   = 6;
	localparam int POS_FORMAT  = 4;
	localparam int POS_MUTE    = 2;
	localparam int POS_HPHOLD  = 1;
	localparam int POS_MASTER  = 0;
	localparam int POS_DIV     = 4;
	localparam int POS_GOUT_EN = 6;
	localparam int POS_SOFT    = 4;
	localparam int POS_ZERO    = 3;

	// ==========================================================
	// Level ramp: 1/8 dB units, 0.5 dB per gain LSB, mute floor.
	localparam int              LVL_W        = 8;
	localparam logic [LVL_W-1:0] MUTE_LEVEL  = 8'h80;
	localparam int              TIMEOUT_SAMP = 512; // Zero-cross timeout, sample periods.

	// ==========================================================
	// Level-change modes and clock divider codes.
	typedef enum logic [1:0] {
		AACR_IMMEDIATE = 2'b00,
		AACR_ZERO_ONLY = 2'b01,
		AACR_SOFT_ONLY = 2'b10,
		AACR_SOFT_ZERO = 2'b11
	} aacr_mode_t;
	localparam logic [2:0] DIV_1P5 = 3'h1;
endpackage

// >>> design/aacr_top.sv
// Purpose: Control register bank of a stereo audio converter.
// Assumes: Control port strobes and frame/zero-cross inputs are synchronous to mclk.
// Notes:   Writes land on the edge after the strobe; reads answer one cycle later.
//
// How it works
// - Identification register read-only, part and revision.
// - Freeze stores writes, applies all on clear.
// - Freezable fields: mute and both gains.
// - Mic power-down bit holds preamp low-power.
// - Converter power-down bit drives its output only; channel levels keep running.
// - Global power-down resets set; host clears it.
// - Power-down leaves all register contents intact.
// - Speed field picks single, double, quad speed.
// - Format bit: left-justified zero, I2S one.
// - Mute bit mutes both serial output channels.
// - Highpass hold freezes and keeps offset subtraction.
// - Bit zero picks serial master or slave.
// - Divider field divides master clock 1-4.
// - Six-bit two's complement gains, half dB.
// - Soft ramp steps 1/8 dB per frame.
// - Zero-cross applies change at crossing or timeout.
// - Each channel tracks zero crossings separately.
// - Soft plus zero-cross: each step waits crossing.
// - Mode field; immediate when clear, both default.
// - Three-bit input select picks gain-stage source.
`timescale 1ns/100ps
module aacr_top #(
	parameter logic [3:0] PART_ID  = 4'h7, // Arbitrary value.
	parameter logic [3:0] REVISION = 4'h3, // Arbitrary value.
	parameter int         TIMEOUT  = aacr_pkg::TIMEOUT_SAMP
) (
	input  wire  logic                          mclk,
	input  wire  logic                          reset_n,
	input  wire  logic [7:0]                    reg_addr,
	input  wire  logic                          reg_wr,
	input  wire  logic [7:0]                    reg_wdata,
	input  wire  logic                          reg_rd,
	output logic [7:0]                          reg_rdata,
	input  wire  logic                          frame_clock_tick,
	input  wire  logic                          zero_cross_a,
	input  wire  logic                          zero_cross_b,
	output logic                                global_power_down,
	output logic                                mic_preamp_power_down,
	output logic                                converter_power_down,
	output logic [1:0]                          speed_mode_field,
	output logic                                serial_format_select,
	output logic                                serial_sample_mute,
	output logic                                highpass_hold,
	output logic                                serial_master,
	output logic                                divided_clock_en,
	output logic                                gain_stage_output_enable,
	output logic [2:0]                          input_source_select,
	output logic signed [aacr_pkg::LVL_W-1:0]   level_a,
	output logic signed [aacr_pkg::LVL_W-1:0]   level_b
);
	// ==========================================================
	// Stored registers, as software sees them, and the read answer.
	logic [7:0] power_ff;      // Power control.
	logic [7:0] conv_ff;       // Converter control.
	logic [7:0] clkdiv_ff;     // Master clock divider.
	logic [7:0] gout_ff;       // Gain-stage output control.
	logic [7:0] gain_b_ff;     // Channel B gain.
	logic [7:0] gain_a_ff;     // Channel A gain.
	logic [7:0] input_ff;      // Input and ramp control.
	logic [7:0] rdata_ff;      // Registered read answer.

	// Applied copies of the freezable fields.
	logic       eff_mute_ff;   // Mute in force.
	logic [5:0] eff_gain_a_ff; // Channel A gain in force.
	logic [5:0] eff_gain_b_ff; // Channel B gain in force.

	// Divider state.
	logic [1:0] div_cnt_ff;    // Position within the divide period.
	logic       div_en_ff;     // Enable pulse at the divided rate.

	aacr_chan_if ch_a ();
	aacr_chan_if ch_b ();

	// ==========================================================
	// Masked write: reserved bits keep their default value.
	function automatic logic [7:0] masked(input logic [7:0] wd, input logic [7:0] wm, input logic [7:0] rst);
		masked = (wd & wm) | (rst & ~wm);
	endfunction

	// Last count of the divide period, one less than its length in master clock cycles; reserved codes fall back to a period of one.
	function automatic logic [1:0] div_last(input logic [2:0] code);
		unique case (code)
			3'h0:    div_last = 2'h0;
			3'h1:    div_last = 2'h2;
			3'h2:    div_last = 2'h1;
			3'h3:    div_last = 2'h2;
			3'h4:    div_last = 2'h3;
			default: div_last = 2'h0;
		endcase
	endfunction

	// Gain code to level in 1/8 dB units: four units per half dB.
	function automatic logic signed [aacr_pkg::LVL_W-1:0] gain_level(input logic [5:0] g);
		gain_level = {g, 2'b00};
	endfunction

	// ==========================================================
	// Register writes. Power-down touches none of these, so settings survive it.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			power_ff  <= aacr_pkg::RST_POWER;
			conv_ff   <= aacr_pkg::RST_CONV;
			clkdiv_ff <= aacr_pkg::RST_CLKDIV;
			gout_ff   <= aacr_pkg::RST_GOUT;
			gain_b_ff <= aacr_pkg::RST_GAIN;
			gain_a_ff <= aacr_pkg::RST_GAIN;
			input_ff  <= aacr_pkg::RST_INPUT;
		end else if (reg_wr) begin
			// Each case writes only through its mask.
			unique case (reg_addr)
				aacr_pkg::ADDR_POWER: begin
					power_ff <= masked(reg_wdata, aacr_pkg::WM_POWER, aacr_pkg::RST_POWER);
				end
				aacr_pkg::ADDR_CONV: begin
					conv_ff <= masked(reg_wdata, aacr_pkg::WM_CONV, aacr_pkg::RST_CONV);
				end
				aacr_pkg::ADDR_CLKDIV: begin
					clkdiv_ff <= masked(reg_wdata, aacr_pkg::WM_CLKDIV, aacr_pkg::RST_CLKDIV);
				end
				aacr_pkg::ADDR_GOUT: begin
					gout_ff <= masked(reg_wdata, aacr_pkg::WM_GOUT, aacr_pkg::RST_GOUT);
				end
				aacr_pkg::ADDR_GAIN_B: begin
					gain_b_ff <= masked(reg_wdata, aacr_pkg::WM_GAIN, aacr_pkg::RST_GAIN);
				end
				aacr_pkg::ADDR_GAIN_A: begin
					gain_a_ff <= masked(reg_wdata, aacr_pkg::WM_GAIN, aacr_pkg::RST_GAIN);
				end
				aacr_pkg::ADDR_INPUT: begin
					input_ff <= masked(reg_wdata, aacr_pkg::WM_INPUT, aacr_pkg::RST_INPUT);
				end
				default: begin
					// Identification and unmapped addresses ignore writes.
				end
			endcase
		end
	end

	// ==========================================================
	// Read answer, registered; unmapped addresses read zero.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_ff <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				aacr_pkg::ADDR_IDENT:  rdata_ff <= {PART_ID, REVISION};
				aacr_pkg::ADDR_POWER:  rdata_ff <= power_ff;
				aacr_pkg::ADDR_CONV:   rdata_ff <= conv_ff;
				aacr_pkg::ADDR_CLKDIV: rdata_ff <= clkdiv_ff;
				aacr_pkg::ADDR_GOUT:   rdata_ff <= gout_ff;
				aacr_pkg::ADDR_GAIN_B: rdata_ff <= gain_b_ff;
				aacr_pkg::ADDR_GAIN_A: rdata_ff <= gain_a_ff;
				aacr_pkg::ADDR_INPUT:  rdata_ff <= input_ff;
				default:               rdata_ff <= 8'h00;
			endcase
		end
	end

	// ==========================================================
	// Freeze: applied copies follow the stored ones only while freeze is clear,
	// so all pending changes land on the same edge.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			eff_mute_ff   <= 1'b0;
			eff_gain_a_ff <= 6'h00;
			eff_gain_b_ff <= 6'h00;
		end else if (!power_ff[aacr_pkg::POS_FREEZE]) begin
			eff_mute_ff   <= conv_ff[aacr_pkg::POS_MUTE];
			eff_gain_a_ff <= gain_a_ff[5:0];
			eff_gain_b_ff <= gain_b_ff[5:0];
		end
	end

	// ==========================================================
	// Master clock divider. The 1.5 setting gives two pulses per three cycles.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			div_cnt_ff <= 2'h0;
			div_en_ff  <= 1'b0;
		end else begin
			if (div_cnt_ff >= div_last(clkdiv_ff[aacr_pkg::POS_DIV +: 3])) begin
				div_cnt_ff <= 2'h0;
			end else begin
				div_cnt_ff <= div_cnt_ff + 2'h1;
			end
			if (clkdiv_ff[aacr_pkg::POS_DIV +: 3] == aacr_pkg::DIV_1P5) begin
				div_en_ff <= (div_cnt_ff != 2'h2);
			end else begin
				div_en_ff <= (div_cnt_ff == 2'h0);
			end
		end
	end

	// ==========================================================
	// Per-channel level logic; each sees only its own zero crossings.
	assign ch_a.frame_tick = frame_clock_tick;
	assign ch_b.frame_tick = frame_clock_tick;
	assign ch_a.zero_cross = zero_cross_a;
	assign ch_b.zero_cross = zero_cross_b;
	assign ch_a.mode       = aacr_pkg::aacr_mode_t'(input_ff[aacr_pkg::POS_ZERO +: 2]);
	assign ch_b.mode       = aacr_pkg::aacr_mode_t'(input_ff[aacr_pkg::POS_ZERO +: 2]);
	// Mute ramps to the floor the same way a gain change does.
	assign ch_a.target     = eff_mute_ff ? aacr_pkg::MUTE_LEVEL : gain_level(eff_gain_a_ff);
	assign ch_b.target     = eff_mute_ff ? aacr_pkg::MUTE_LEVEL : gain_level(eff_gain_b_ff);

	aacr_level_chan #(.TIMEOUT(TIMEOUT)) u_chan_a (
		.mclk    (mclk),
		.reset_n (reset_n),
		.ch      (ch_a.chan)
	);
	aacr_level_chan #(.TIMEOUT(TIMEOUT)) u_chan_b (
		.mclk    (mclk),
		.reset_n (reset_n),
		.ch      (ch_b.chan)
	);

	// ==========================================================
	// Outputs, each a slice of a flip-flop.
	assign reg_rdata                = rdata_ff;
	assign global_power_down        = power_ff[aacr_pkg::POS_PD_ALL];
	assign mic_preamp_power_down    = power_ff[aacr_pkg::POS_PD_MIC];
	assign converter_power_down     = power_ff[aacr_pkg::POS_PD_CONV];
	assign speed_mode_field         = conv_ff[aacr_pkg::POS_SPEED +: 2];
	assign serial_format_select     = conv_ff[aacr_pkg::POS_FORMAT];
	assign serial_sample_mute       = eff_mute_ff;
	assign highpass_hold            = conv_ff[aacr_pkg::POS_HPHOLD];
	assign serial_master            = conv_ff[aacr_pkg::POS_MASTER];
	assign divided_clock_en         = div_en_ff;
	assign gain_stage_output_enable = gout_ff[aacr_pkg::POS_GOUT_EN];
	assign input_source_select      = input_ff[2:0];
	assign level_a                  = ch_a.level;
	assign level_b                  = ch_b.level;

	// ==========================================================
	// Checks.
	ident_read_a: assert property (@(posedge mclk) disable iff (!reset_n)
		(reg_rd && reg_addr == aacr_pkg::ADDR_IDENT) |=> (reg_rdata == {PART_ID, REVISION}))
		else $error("Identification read wrong.");
	freeze_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
		(power_ff[aacr_pkg::POS_FREEZE] && $past(power_ff[aacr_pkg::POS_FREEZE])) |-> $stable(eff_gain_a_ff))
		else $error("Gain changed while frozen.");
	freeze_release_a: assert property (@(posedge mclk) disable iff (!reset_n)
		$fell(power_ff[aacr_pkg::POS_FREEZE]) |=> (eff_gain_b_ff == $past(gain_b_ff[5:0])
			&& eff_mute_ff == $past(conv_ff[aacr_pkg::POS_MUTE])))
		else $error("Pending values not applied on release.");
	pd_write_a: assert property (@(posedge mclk) disable iff (!reset_n)
		(reg_wr && reg_addr == aacr_pkg::ADDR_POWER) |=> (mic_preamp_power_down == $past(reg_wdata[3])
			&& converter_power_down == $past(reg_wdata[2])))
		else $error("Power-down bits not taken.");
	pd_keep_a: assert property (@(posedge mclk) disable iff (!reset_n)
		$rose(global_power_down) |-> $stable(conv_ff) && $stable(gain_a_ff))
		else $error("Settings lost on power-down.");
	reserved_read_a: assert property (@(posedge mclk) disable iff (!reset_n)
		(reg_rd && reg_addr == aacr_pkg::ADDR_GOUT) |=> (reg_rdata[5:0] == 6'h00 && !reg_rdata[7]))
		else $error("Reserved bits read nonzero.");
	div_two_a: assert property (@(posedge mclk) disable iff (!reset_n)
		(clkdiv_ff[6:4] == 3'h2 && $stable(clkdiv_ff) && divided_clock_en) |=> !divided_clock_en)
		else $error("Divide by two pulsed twice in a row.");
	mute_path_a: assert property (@(posedge mclk) disable iff (!reset_n)
		(!power_ff[aacr_pkg::POS_FREEZE] && conv_ff[aacr_pkg::POS_MUTE]) |=> serial_sample_mute)
		else $error("Mute not applied.");
endmodule

// >>> testbench/aacr_host_model.sv
// Purpose: Host controller model that drives the control port of the register bank.
// Assumes: Strobes are taken on the rising mclk edge; read data is registered there.
// Notes:   Write data shows the inverse of the last byte when idle.
`timescale 1ns/100ps
module aacr_host_model (
	input  wire logic       mclk,
	output logic [7:0]      reg_addr,
	output logic            reg_wr,
	output logic [7:0]      reg_wdata,
	output logic            reg_rd,
	input  wire logic [7:0] reg_rdata
);
	// ==========================================================
	// Idle bus state, defined from time zero.
	initial begin
		reg_addr  = 8'h00;
		reg_wr    = 1'b0;
		reg_wdata = 8'h00;
		reg_rd    = 1'b0;
	end
	// One-cycle write strobe; data is scrambled afterwards so a stale byte never looks valid.
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		#1;
		reg_addr  = a;
		reg_wdata = d;
		reg_wr    = 1'b1;
		@(posedge mclk);
		#1;
		reg_wr    = 1'b0;
		reg_wdata = ~d;
	endtask
	// One-cycle read strobe; the answer is taken once the strobe's edge has landed.
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		#1;
		reg_addr = a;
		reg_rd   = 1'b1;
		@(posedge mclk);
		#1;
		reg_rd = 1'b0;
		d      = reg_rdata;
	endtask
endmodule

// >>> testbench/aacr_top_bench.sv
// Purpose: Self-checking bench for the register bank through its control port.
// Assumes: TIMEOUT shortened to 4 sample periods; frame ticks and crossings come from the bench.
// Notes:   Levels are in 1/8 dB, gain code times four.
`timescale 1ns/100ps
module aacr_top_bench;
	// ==========================================================
	// Constants and signals.
	localparam int         TMO = 4;      // Short timeout keeps the run brief.
	localparam logic [7:0] ID  = 8'h73;  // Arbitrary identification value.
	localparam logic [7:0] ADR [8] = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09};
	localparam logic [7:0] RST [8] = '{ID, aacr_pkg::RST_POWER, aacr_pkg::RST_CONV, aacr_pkg::RST_CLKDIV,
		aacr_pkg::RST_GOUT, aacr_pkg::RST_GAIN, aacr_pkg::RST_GAIN, aacr_pkg::RST_INPUT};
	localparam logic [7:0] MSK [8] = '{8'h00, aacr_pkg::WM_POWER, aacr_pkg::WM_CONV, aacr_pkg::WM_CLKDIV,
		aacr_pkg::WM_GOUT, aacr_pkg::WM_GAIN, aacr_pkg::WM_GAIN, aacr_pkg::WM_INPUT};
	localparam int         DV  [6] = '{12, 8, 6, 4, 3, 12}; // Enables per 12 cycles by divider code.
	logic                  mclk, reset_n, reg_wr, reg_rd;
	logic [7:0]            reg_addr, reg_wdata, reg_rdata, rv;
	logic [2:0]            ev;           // Zero-cross B, zero-cross A, frame tick.
	logic                  gpd, mpd, cpd, sfs, mute, hph, mst, dce, goe;
	logic [1:0]            spd;
	logic [2:0]            src;
	logic signed [7:0]     lva, lvb;
	int                    err_total, checks, n;

	aacr_top #(.PART_ID(ID[7:4]), .REVISION(ID[3:0]), .TIMEOUT(TMO)) aacr_top_inst (
		.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_clock_tick(ev[0]), .zero_cross_a(ev[1]),
		.zero_cross_b(ev[2]), .global_power_down(gpd), .mic_preamp_power_down(mpd),
		.converter_power_down(cpd), .speed_mode_field(spd), .serial_format_select(sfs),
		.serial_sample_mute(mute), .highpass_hold(hph), .serial_master(mst), .divided_clock_en(dce),
		.gain_stage_output_enable(goe), .input_source_select(src), .level_a(lva), .level_b(lvb));
	aacr_host_model host (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata));

	// ==========================================================
	// Shared tasks.
	task automatic complete_run();
		if (err_total == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Counts every comparison and reports a mismatch at once.
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		host.read_reg(a, rv);
		chk("readback", exp, rv);
	endtask
	// One-cycle event pulse, then two cycles so the level update has landed.
	task automatic pulse(input logic [2:0] m);
		@(posedge mclk);
		#1 ev = m;
		@(posedge mclk);
		#1 ev = 3'h0;
		repeat (2) @(posedge mclk);
		#1;
	endtask
	// Bounded wait for both levels; running out of cycles ends the run.
	task automatic settle(input logic [7:0] ea, input logic [7:0] eb);
		int k;
		k = 0;
		while ((lva !== ea || lvb !== eb) && k < 16) begin
			@(posedge mclk);
			#1 k++;
		end
		chk("level_a", ea, lva);
		chk("level_b", eb, lvb);
		if (k == 16) complete_run();
	endtask

	// ==========================================================
	// Clock and main sequence.
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	initial begin
		reset_n   = 1'b0;
		ev        = 3'h0;
		err_total = 0;
		checks    = 0;
		repeat (4) @(posedge mclk);
		#1 reset_n = 1'b1;
		// Reset contents, an unmapped place and reset-level outputs.
		for (int i = 0; i < 8; i++) rdc(ADR[i], RST[i]);
		rdc(8'h03, 8'h00);
		chk("power_outputs", 8'h80, {gpd, mpd, cpd, spd, sfs, hph, mst});
		chk("gout_and_source", 8'h09, {4'h0, goe, src});
		// All ones to every writable register: reserved bits stay at default, identification ignores writes.
		for (int i = 1; i < 8; i++) host.write_reg(ADR[i], 8'hff);
		host.write_reg(8'h01, 8'h00);
		for (int i = 0; i < 8; i++) rdc(ADR[i], (8'hff & MSK[i]) | (RST[i] & ~MSK[i]));
		chk("control_outputs", 8'hff, {gpd, mpd, cpd, spd, sfs, hph, mst});
		chk("gout_and_source", 8'h0f, {4'h0, goe, src});
		chk("mute_frozen", 8'h00, {7'h0, mute});
		host.write_reg(8'h02, 8'h0d);
		repeat (2) @(posedge mclk);
		#1 chk("mute_applied", 8'h01, {7'h0, mute});
		for (int i = 1; i < 8; i++) host.write_reg(ADR[i], 8'h00);
		chk("control_outputs", 8'h00, {gpd, mpd, cpd, spd, sfs, hph, mst});
		chk("gout_and_source", 8'h00, {4'h0, goe, src});
		// Speed codes zero to two reach their field.
		for (int s = 0; s < 3; s++) begin
			host.write_reg(8'h04, 8'(s << 6));
			chk("speed_mode", 8'(s), {6'h0, spd});
		end
		host.write_reg(8'h04, 8'h00);
		// Divider codes zero to four and reserved code five, counted over twelve cycles.
		for (int c = 0; c < 6; c++) begin
			host.write_reg(8'h05, 8'(c << 4));
			repeat (3) @(posedge mclk);
			n = 0;
			repeat (12) begin
				@(posedge mclk);
				#1 if (dce === 1'b1) n++;
			end
			chk("divided_clock_en", 8'(DV[c]), 8'(n));
		end
		// Freeze holds the channel A gain until it clears, then both gains apply.
		host.write_reg(8'h09, 8'h01);
		host.write_reg(8'h02, 8'h80);
		host.write_reg(8'h08, 8'h10);
		host.write_reg(8'h07, 8'h3c);
		repeat (4) @(posedge mclk);
		#1 chk("level_a_frozen", 8'h00, lva);
		rdc(8'h08, 8'h10);
		host.write_reg(8'h02, 8'h00);
		settle(8'h40, 8'hf0);
		host.write_reg(8'h04, 8'h04);
		settle(8'h80, 8'h80);
		host.write_reg(8'h04, 8'h00);
		settle(8'h40, 8'hf0);
		// Soft ramp: one eighth of a dB per frame tick, 1 dB after eight ticks.
		host.write_reg(8'h09, 8'h11);
		host.write_reg(8'h08, 8'h12);
		for (int i = 1; i <= 8; i++) begin
			pulse(3'b001);
			chk("level_a_ramp", 8'h40 + 8'(i), lva);
		end
		chk("level_b_ramp", 8'hf0, lvb);
		// Zero cross only: A jumps on its crossing, B waits for the timeout.
		host.write_reg(8'h09, 8'h09);
		host.write_reg(8'h08, 8'h00);
		host.write_reg(8'h07, 8'h00);
		pulse(3'b010);
		chk("level_a_cross", 8'h00, lva);
		chk("level_b_wait", 8'hf0, lvb);
		repeat (TMO - 1) pulse(3'b001);
		chk("level_b_wait", 8'hf0, lvb);
		n = 0;
		while (lvb !== 8'h00 && n < TMO + 1) begin
			pulse(3'b001);
			n++;
		end
		chk("level_b_timeout", 8'h00, lvb);
		// Soft ramp with zero cross: one step per crossing.
		host.write_reg(8'h09, 8'h19);
		host.write_reg(8'h08, 8'h01);
		pulse(3'b010);
		chk("level_a_step", 8'h01, lva);
		pulse(3'b010);
		chk("level_a_step", 8'h02, lva);
		chk("level_b_idle", 8'h00, lvb);
		// Entering global power-down must leave the channel A gain and input settings readable.
		host.write_reg(8'h02, 8'h01);
		chk("global_power_down", 8'h01, {7'h0, gpd});
		rdc(8'h08, 8'h01);
		rdc(8'h09, 8'h19);
		complete_run();
	end
endmodule
